// >>> src/i2csr_top.sv
/*
 * Slave-receive controller of a two-wire serial bus with AXI4-Lite registers.
 * Assumes an external bus master drives the lines and software at the registers
 * reads each byte before the next one completes, or accepts a stretched clock.
 */
`timescale 1ns/1ns
`default_nettype none

module i2csr_top (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [i2csr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output var  logic                         s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output var  logic                         s_axi_wready,
    output var  logic [1:0]                   s_axi_bresp,
    output var  logic                         s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [i2csr_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output var  logic                         s_axi_arready,
    output var  logic [31:0]                  s_axi_rdata,
    output var  logic [1:0]                   s_axi_rresp,
    output var  logic                         s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire logic                         scl_in,
    output var  logic                         scl_out,
    output var  logic                         scl_oe_n,
    input  wire logic                         sda_in,
    output var  logic                         sda_out,
    output var  logic                         sda_oe_n,
    output var  logic                         irq
);

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        i2csr_pkg::i2csr_state_e  state;
        logic                     bus_interface_enable;
        logic                     interface_interrupt_enable;
        logic                     master_select;
        logic                     transmit_select;
        logic                     interface_interrupt_flag;
        logic                     busy;
        logic                     full;
        logic                     bit_order_select;
        logic [6:0]               own;
        logic [7:0]               data;
        logic [i2csr_pkg::EV_W-1:0] sts;
        logic [i2csr_pkg::EV_W-1:0] ien;
        logic                     restart;
        logic                     pin_lvl;
        logic                     scl_oe_n;
        logic                     sda_oe_n;
        logic                     irq;
        logic                     awready;
        logic                     wready;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     arready;
        logic                     rvalid;
        logic [1:0]               rresp;
        logic [31:0]              rdata;
    } i2csr_top_s;

    i2csr_top_s r;
    i2csr_top_s next_r;
    logic       wr;
    logic       rd;

    i2csr_line_if line ();

    // ********************************************************************
    // Line front end
    // ********************************************************************
    i2csr_line_mon u_mon (
        .clk    (clk),
        .rst    (rst),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .line   (line)
    );

    i2csr_shifter u_shf (
        .clk  (clk),
        .rst  (rst),
        .line (line)
    );

    // Addresses always arrive most significant bit first, whatever the data order.
    assign line.lsb_first = r.bit_order_select && (r.state != i2csr_pkg::ST_ADDR);
    assign line.restart   = r.restart;

    // ********************************************************************
    // Register decode
    // ********************************************************************
    function automatic logic mapped(input logic [i2csr_pkg::ADDR_W-1:0] a);
        case (a)
            i2csr_pkg::OFS_CTRL,
            i2csr_pkg::OFS_MODE,
            i2csr_pkg::OFS_DATA,
            i2csr_pkg::OFS_OWN,
            i2csr_pkg::OFS_STS,
            i2csr_pkg::OFS_CLR,
            i2csr_pkg::OFS_IEN: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] rd_word(input i2csr_top_s s,
                                            input logic [i2csr_pkg::ADDR_W-1:0] a);
        case (a)
            i2csr_pkg::OFS_CTRL: rd_word = {25'h0, s.full, s.busy, s.interface_interrupt_flag, s.transmit_select,
                                            s.master_select, s.interface_interrupt_enable, s.bus_interface_enable};
            i2csr_pkg::OFS_MODE: rd_word = {31'h0, s.bit_order_select};
            i2csr_pkg::OFS_DATA: rd_word = {24'h0, s.data};
            i2csr_pkg::OFS_OWN:  rd_word = {25'h0, s.own};
            i2csr_pkg::OFS_STS:  rd_word = {29'h0, s.sts};
            i2csr_pkg::OFS_IEN:  rd_word = {29'h0, s.ien};
            default:             rd_word = 32'h0;
        endcase
    endfunction

    assign wr = s_axi_awvalid && s_axi_wvalid && !r.bvalid && !r.awready;
    assign rd = s_axi_arvalid && !r.rvalid && !r.arready;

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        next_r         = r;
        next_r.restart = 1'b0;
        next_r.awready = 1'b0;
        next_r.wready  = 1'b0;
        next_r.arready = 1'b0;

        // Software clears come first so that a hardware set in the same cycle wins.
        if (wr) begin
            next_r.awready = 1'b1;
            next_r.wready  = 1'b1;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = mapped(s_axi_awaddr) ? i2csr_pkg::RESP_OK : i2csr_pkg::RESP_ERR;
            if (s_axi_wstrb[0]) begin
                case (s_axi_awaddr)
                    i2csr_pkg::OFS_CTRL: begin
                        next_r.bus_interface_enable  = s_axi_wdata[i2csr_pkg::CTRL_ICE];
                        next_r.interface_interrupt_enable = s_axi_wdata[i2csr_pkg::CTRL_INTERFACE_INTERRUPT_ENABLE];
                        next_r.master_select  = s_axi_wdata[i2csr_pkg::CTRL_MST];
                        next_r.transmit_select  = s_axi_wdata[i2csr_pkg::CTRL_TRS];
                        if (!s_axi_wdata[i2csr_pkg::CTRL_INTERFACE_INTERRUPT_FLAG]) begin
                            next_r.interface_interrupt_flag = 1'b0;
                        end
                    end
                    i2csr_pkg::OFS_MODE: next_r.bit_order_select = s_axi_wdata[i2csr_pkg::MODE_MLS];
                    i2csr_pkg::OFS_OWN:  next_r.own = s_axi_wdata[6:0];
                    i2csr_pkg::OFS_CLR:  next_r.sts = r.sts & ~s_axi_wdata[i2csr_pkg::EV_W-1:0];
                    i2csr_pkg::OFS_IEN:  next_r.ien = s_axi_wdata[i2csr_pkg::EV_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end

        if (rd) begin
            next_r.arready = 1'b1;
            next_r.rvalid  = 1'b1;
            next_r.rresp   = mapped(s_axi_araddr) ? i2csr_pkg::RESP_OK : i2csr_pkg::RESP_ERR;
            next_r.rdata   = rd_word(r, s_axi_araddr);
            if (s_axi_araddr == i2csr_pkg::OFS_DATA) begin
                next_r.full = 1'b0;
            end
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end

        // A disabled interface lets go of both lines and forgets the transfer.
        if (!r.bus_interface_enable) begin
            next_r.state    = i2csr_pkg::ST_IDLE;
            next_r.busy     = 1'b0;
            next_r.scl_oe_n = 1'b1;
            next_r.sda_oe_n = 1'b1;
        end else if (line.stop_det) begin
            next_r.busy     = 1'b0;
            next_r.state    = i2csr_pkg::ST_IDLE;
            next_r.scl_oe_n = 1'b1;
            next_r.sda_oe_n = 1'b1;
            next_r.sts[i2csr_pkg::EV_STOP] = 1'b1;
        end else if (line.start_det) begin
            next_r.busy     = 1'b1;
            next_r.state    = i2csr_pkg::ST_ADDR;
            next_r.scl_oe_n = 1'b1;
            next_r.sda_oe_n = 1'b1;
            next_r.sts[i2csr_pkg::EV_START] = 1'b1;
        end else begin
            case (r.state)
                i2csr_pkg::ST_ADDR: begin
                    if (line.scl_fall && line.bit_cnt == i2csr_pkg::BYTE_BITS) begin
                        if (line.shift_byte[7:1] == r.own && !line.shift_byte[0]) begin
                            next_r.transmit_select      = 1'b0;
                            next_r.sda_oe_n = 1'b0;
                            next_r.interface_interrupt_flag     = 1'b1;
                            next_r.state    = i2csr_pkg::ST_ACK;
                        end else begin
                            next_r.state = i2csr_pkg::ST_SKIP;
                        end
                    end
                end
                i2csr_pkg::ST_DATA: begin
                    if (line.scl_fall && line.bit_cnt == i2csr_pkg::BYTE_BITS) begin
                        if (!r.full) begin
                            next_r.data     = line.shift_byte;
                            next_r.full     = 1'b1;
                            next_r.interface_interrupt_flag     = 1'b1;
                            next_r.sda_oe_n = 1'b0;
                            next_r.sts[i2csr_pkg::EV_BYTE] = 1'b1;
                            next_r.state    = i2csr_pkg::ST_ACK;
                        end else begin
                            next_r.scl_oe_n = 1'b0;
                            next_r.state    = i2csr_pkg::ST_HOLD;
                        end
                    end
                end
                i2csr_pkg::ST_HOLD: begin
                    // The clock stays stretched; the byte waits in the shifter meanwhile.
                    if (!r.full) begin
                        next_r.data     = line.shift_byte;
                        next_r.full     = 1'b1;
                        next_r.interface_interrupt_flag     = 1'b1;
                        next_r.sda_oe_n = 1'b0;
                        next_r.scl_oe_n = 1'b1;
                        next_r.sts[i2csr_pkg::EV_BYTE] = 1'b1;
                        next_r.state    = i2csr_pkg::ST_ACK;
                    end
                end
                i2csr_pkg::ST_ACK: begin
                    if (line.scl_fall) begin
                        next_r.sda_oe_n = 1'b1;
                        next_r.restart  = 1'b1;
                        next_r.state    = i2csr_pkg::ST_DATA;
                    end
                end
                i2csr_pkg::ST_IDLE,
                i2csr_pkg::ST_SKIP: begin
                end
                default: begin
                    next_r.state = i2csr_pkg::ST_IDLE;
                end
            endcase
        end

        next_r.irq = (next_r.interface_interrupt_flag && next_r.interface_interrupt_enable) || |(next_r.sts & next_r.ien);
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r          <= '0;
            r.state    <= i2csr_pkg::ST_IDLE;
            r.own      <= i2csr_pkg::RST_OWN;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign s_axi_awready = r.awready;
    assign s_axi_wready  = r.wready;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_arready = r.arready;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign s_axi_rvalid  = r.rvalid;
    assign scl_out       = r.pin_lvl;
    assign scl_oe_n      = r.scl_oe_n;
    assign sda_out       = r.pin_lvl;
    assign sda_oe_n      = r.sda_oe_n;
    assign irq           = r.irq;

endmodule

`default_nettype wire

// >>> src/i2csr_pkg.sv
/*
 * Shared constants and types of the two-wire slave receiver.
 * Assumes a single 100 MHz system clock and a 32-bit register bus.
 */
`default_nettype none

package i2csr_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam int         ADDR_W   = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_OWN  = 8'h0c;
    localparam logic [7:0] OFS_STS  = 8'h10;
    localparam logic [7:0] OFS_CLR  = 8'h14;
    localparam logic [7:0] OFS_IEN  = 8'h18;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int CTRL_ICE  = 0;
    localparam int CTRL_INTERFACE_INTERRUPT_ENABLE = 1;
    localparam int CTRL_MST  = 2;
    localparam int CTRL_TRS  = 3;
    localparam int CTRL_INTERFACE_INTERRUPT_FLAG = 4;
    localparam int MODE_MLS  = 0;
    localparam int EV_BYTE   = 0;
    localparam int EV_STOP   = 1;
    localparam int EV_START  = 2;
    localparam int EV_W      = 3;

    // ********************************************************************
    // Reset values and counts
    // ********************************************************************
    localparam logic [6:0] RST_OWN   = 7'h2a;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] RESP_OK   = 2'h0;
    localparam logic [1:0] RESP_ERR  = 2'h2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_DATA = 6'h04,
        ST_ACK  = 6'h08,
        ST_HOLD = 6'h10,
        ST_SKIP = 6'h20
    } i2csr_state_e;

endpackage

`default_nettype wire

// >>> src/i2csr_line_if.sv
/*
 * Carrier between the line monitor, the bit shifter and the controller.
 * Assumes all three run on the same system clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface i2csr_line_if;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       restart;
    logic       lsb_first;
    logic [3:0] bit_cnt;
    logic [7:0] shift_byte;

    modport mon (output sda, scl_rise, scl_fall, start_det, stop_det);
    modport shf (input sda, scl_rise, start_det, restart, lsb_first,
                 output bit_cnt, shift_byte);
    modport ctl (input scl_fall, start_det, stop_det, bit_cnt, shift_byte,
                 output restart, lsb_first);
endinterface

`default_nettype wire

// >>> src/i2csr_line_mon.sv
/*
 * Synchronises both bus lines and finds clock edges, start and stop.
 * Assumes the line inputs are asynchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none

module i2csr_line_mon (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   scl_in,
    input  wire logic   sda_in,
    i2csr_line_if.mon   line
);
    // Bit 0 carries the clock line, bit 1 the data line.
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] prev;
    } i2csr_mon_s;

    i2csr_mon_s r;
    i2csr_mon_s next_r;

    always_comb begin
        next_r      = r;
        next_r.s1   = {sda_in, scl_in};
        next_r.s2   = r.s1;
        next_r.prev = r.s2;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{s1: 2'h3, s2: 2'h3, prev: 2'h3};
        end else begin
            r <= next_r;
        end
    end

    assign line.sda       = r.s2[1];
    assign line.scl_rise  = r.s2[0] & ~r.prev[0];
    assign line.scl_fall  = ~r.s2[0] & r.prev[0];
    assign line.start_det = r.s2[0] & r.prev[0] & r.prev[1] & ~r.s2[1];
    assign line.stop_det  = r.s2[0] & r.prev[0] & ~r.prev[1] & r.s2[1];
endmodule

`default_nettype wire

// >>> src/i2csr_shifter.sv
/*
 * Collects eight data-line samples, one per rising clock-line edge.
 * Assumes restart pulses only while the clock line is low.
 */
`timescale 1ns/1ns
`default_nettype none

module i2csr_shifter (
    input  wire logic   clk,
    input  wire logic   rst,
    i2csr_line_if.shf   line
);
    typedef struct packed {
        logic [3:0] cnt;
        logic [7:0] sh;
    } i2csr_shf_s;

    i2csr_shf_s r;
    i2csr_shf_s next_r;

    always_comb begin
        next_r = r;
        if (line.start_det || line.restart) begin
            next_r.cnt = 4'h0;
            next_r.sh  = 8'h00;
        end else if (line.scl_rise && r.cnt != i2csr_pkg::BYTE_BITS) begin
            // The ninth rise is not shifted, so the own acknowledge never lands here.
            next_r.cnt = r.cnt + 4'h1;
            next_r.sh  = line.lsb_first ? {line.sda, r.sh[7:1]}
                                        : {r.sh[6:0], line.sda};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{cnt: 4'h0, sh: 8'h00};
        end else begin
            r <= next_r;
        end
    end

    assign line.bit_cnt    = r.cnt;
    assign line.shift_byte = r.sh;
endmodule

`default_nettype wire

// >>> tb/i2csr_top_properties.sv
/* Port checker of the two-wire slave receiver.
   Assumes it is bound onto i2csr_top and that one clock drives all of it. */
`timescale 1ns/1ns
`default_nettype none
module i2csr_top_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        scl_in,
    input wire logic        scl_oe_n,
    input wire logic        sda_oe_n,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire aw_tk = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire ar_tk = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    wire rd_dat = ar_tk && (s_axi_araddr == 8'h08);
    // ****************************************
    // Acknowledge must be held for six cycles once it begins.
    // ****************************************
    sequence s_ack_hold;
        !sda_oe_n [*6];
    endsequence
    a_wr_answer: assert property (aw_tk |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
        else $error("write not answered");
    a_rd_answer: assert property (ar_tk |=> s_axi_arready && s_axi_rvalid)
        else $error("read not answered");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    a_wr_unmapped: assert property (aw_tk && s_axi_awaddr > 8'h18 |=> s_axi_bresp == 2'h2)
        else $error("unmapped write not refused");
    a_rd_unmapped: assert property (ar_tk && s_axi_araddr > 8'h18 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_ack_in_low: assert property ($fell(sda_oe_n) |-> !$past(scl_in))
        else $error("ack began with clock high");
    a_ack_span: assert property ($fell(sda_oe_n) |-> s_ack_hold)
        else $error("ack too short");
    a_stretch_low: assert property ($fell(scl_oe_n) |-> !scl_in && !$past(scl_in))
        else $error("stretch began with clock high");
    a_stretch_rel: assert property ($rose(scl_oe_n) |->
        $past(rd_dat, 2) || $past(rd_dat, 3) || $past(rd_dat, 4))
        else $error("stretch released without data read");
    a_irq_by_write: assert property ($fell(irq) |->
        $past(aw_tk) || $past(aw_tk, 2) || $past(aw_tk, 3))
        else $error("irq dropped without a write");
endmodule
bind i2csr_top i2csr_top_properties i2csr_top_properties_inst (.*);
`default_nettype wire

// >>> tb/i2csr_master_model.sv
/* Behavioural two-wire bus master that writes bytes to the slave.
   Assumes open-drain lines with pull-ups resolved by the bench. */
`timescale 1ns/1ns
`default_nettype none
module i2csr_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output var  logic scl_drv,
    output var  logic sda_drv
);
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Bounded wait, so a clock held low forever cannot hang the run.
    task automatic rise();
        int k;
        scl_drv = 1'b1;
        for (k = 0; k < 3000 && !scl; k++) #10;
        #20;
    endtask
    // Each call starts 3 ns later in the clock phase, so no line change meets a clock edge.
    task automatic start();
        #13 sda_drv = 1'b1;
        #30 scl_drv = 1'b1;
        #40 sda_drv = 1'b0;
        #40 scl_drv = 1'b0;
    endtask
    task automatic stop();
        #13 sda_drv = 1'b0;
        #30 scl_drv = 1'b1;
        #40 sda_drv = 1'b1;
        #40;
    endtask
    // Data changes 10 ns after the clock falls, never beside it.
    task automatic xfer(input logic [7:0] b, output logic ack);
        int i;
        #3;
        for (i = 7; i >= 0; i--) begin
            #10 sda_drv = b[i];
            #30 rise();
            #20 scl_drv = 1'b0;
        end
        #10 sda_drv = 1'b1;
        #70 rise();
        ack = sda;
        #20 scl_drv = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
/* Self-checking bench of the two-wire slave receiver.
   Assumes the master model and the bound port checker. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic [1:0]  r;
    } i2csr_row_s;
    logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n, irq;
    logic        scl_drv, sda_drv, ack;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          mismatches, compares, k;
    i2csr_row_s  rows [7] = '{'{8'h04, 32'h1, 32'h1, 2'h0}, '{8'h0c, 32'haa, 32'h2a, 2'h0},
        '{8'h18, 32'h2, 32'h2, 2'h0}, '{8'h10, 32'hff, 32'h0, 2'h0},
        '{8'h14, 32'h7, 32'h0, 2'h0}, '{8'h1c, 32'h5, 32'h0, 2'h2},
        '{8'h00, 32'h1b, 32'h0b, 2'h0}};
    // Open-drain lines: low while either party pulls.
    assign scl_in = scl_drv && (scl_oe_n || scl_out);
    assign sda_in = sda_drv && (sda_oe_n || sda_out);
    i2csr_top i2csr_top_inst (.*);
    i2csr_master_model i2csr_master_model_inst (.scl(scl_in), .sda(sda_in),
        .scl_drv(scl_drv), .sda_drv(sda_drv));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        $display("unexpected timeout exp answer got none");
        tally_and_finish();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 50) hang();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 50) hang();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  rs;
        rd(a, d, rs);
        `CHK("rdata", e, d)
    endtask
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, r);
            `CHK("bresp", rows[i].r, r)
            rd(rows[i].a, q, r);
            `CHK("rdata", rows[i].q, q)
            `CHK("rresp", rows[i].r, r)
        end
        $display("register rows done");
        i2csr_master_model_inst.start();
        i2csr_master_model_inst.xfer(8'h54, ack);
        `CHK("addr ack", 1'b0, ack)
        rdchk(8'h00, 32'h33);
        `CHK("irq", 1'b1, irq)
        wr(8'h00, 32'h03, r);
        @(posedge clk);
        `CHK("irq", 1'b0, irq)
        i2csr_master_model_inst.xfer(8'h01, ack);
        `CHK("data ack", 1'b0, ack)
        `CHK("irq", 1'b1, irq)
        rdchk(8'h08, 32'h80);
        wr(8'h04, 32'h0, r);
        i2csr_master_model_inst.xfer(8'hc5, ack);
        `CHK("data ack", 1'b0, ack)
        $display("address and first bytes done");
        fork
            i2csr_master_model_inst.xfer(8'h3c, ack);
            begin
                for (k = 0; k < 200 && scl_oe_n; k++) @(posedge clk);
                repeat (20) @(posedge clk);
                `CHK("stretch", 1'b0, scl_oe_n)
                rdchk(8'h08, 32'hc5);
            end
        join
        `CHK("data ack", 1'b0, ack)
        rdchk(8'h08, 32'h3c);
        $display("stretch done");
        i2csr_master_model_inst.stop();
        rdchk(8'h00, 32'h13);
        rdchk(8'h10, 32'h7);
        wr(8'h00, 32'h03, r);
        @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wr(8'h18, 32'h0, r);
        @(posedge clk);
        `CHK("irq", 1'b0, irq)
        wr(8'h14, 32'h7, r);
        rdchk(8'h10, 32'h0);
        $display("stop and interrupts done");
        i2csr_master_model_inst.start();
        i2csr_master_model_inst.xfer(8'h56, ack);
        `CHK("foreign ack", 1'b1, ack)
        i2csr_master_model_inst.start();
        i2csr_master_model_inst.xfer(8'h55, ack);
        `CHK("read ack", 1'b1, ack)
        i2csr_master_model_inst.stop();
        rdchk(8'h00, 32'h03);
        $display("refused frames done");
        wr(8'h0c, 32'h11, r);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        `CHK("line release", 2'h3, {scl_oe_n, sda_oe_n})
        `CHK("pin level", 2'h0, {scl_out, sda_out})
        rst <= 1'b0;
        rdchk(8'h0c, 32'h2a);
        i2csr_master_model_inst.start();
        i2csr_master_model_inst.xfer(8'h54, ack);
        `CHK("disabled ack", 1'b1, ack)
        i2csr_master_model_inst.stop();
        rdchk(8'h00, 32'h0);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
